// ### logic/bfa_datapath.sv
// Butterfly and accumulate datapath with its product FIFO.
// Assumes one clock, products synchronous to it, and a byte-wide RAM that
// takes a write byte while ramWrite is high and offers a read byte while ramRead is high.
// Notes on behaviour
// RULE_01 - Cycle 1: stage 24 bits, write byte, reload.
// RULE_02 - Cycles 2-4: write staged bytes, keep accumulating.
// RULE_03 - Cycles 5-8: read stored sum bytewise.
// RULE_04 - Schedule wraps after cycle 8.
// RULE_05 - Imaginary accumulator runs alongside, same schedule.
// RULE_06 - Both adder stages give 16-bit results.
// RULE_07 - Products arrive as A, C, B, D.
// RULE_08 - Four butterfly terms per group.
// RULE_09 - First stage pairs A/C then B/D.
// RULE_10 - Upper hold register loads on even cycles.
// RULE_11 - Results registered; one term per cycle.
// RULE_12 - Radix-2 bypasses second stage.
// RULE_13 - Upper accumulator bits count carries.
// RULE_14 - Output pins also carry RAM bytes.
// RULE_15 - 16-bit inputs summed to 32-bit totals.
// RULE_16 - Words move as four bytes, four cycles.
// RULE_17 - Everything runs from one clock.
// RULE_18 - Static mode selects the operation.
// RULE_19 - Group strobe aligns both schedules.

// Small FIFO with valid and ready on both sides.
module bfa_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock, reset and freeze.
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             clkEn,
  // Filling side.
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Draining side.
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];  // Storage words.
  logic [PTR_W-1:0] wrPtr;        // Next slot to fill.
  logic [PTR_W-1:0] rdPtr;        // Oldest slot.
  logic [CNT_W-1:0] count;        // Words held.
  logic             doWrite;      // A word is taken this cycle.
  logic             doRead;       // A word leaves this cycle.

  // Full refuses a write even when a read frees a slot in the same cycle.
  assign inReady = (count != CNT_W'(DEPTH));
  assign outValid = (count != '0);
  assign doWrite = clkEn & inValid & inReady;
  assign doRead = clkEn & outValid & outReady;
  assign outData = mem[rdPtr];

  // Pointers and fill level.
  always_ff @(posedge clock) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doWrite) begin
        wrPtr <= (wrPtr == PTR_W'(DEPTH - 1)) ? '0 : wrPtr + PTR_W'(1);
      end
      if (doRead) begin
        rdPtr <= (rdPtr == PTR_W'(DEPTH - 1)) ? '0 : rdPtr + PTR_W'(1);
      end
      count <= count + CNT_W'(doWrite) - CNT_W'(doRead);
    end
  end

  // Storage array; data needs no reset.
  always_ff @(posedge clock) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end
endmodule

// Datapath top.
module bfa_datapath (
  // Clock, reset and freeze.
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               clkEn,
  // Static mode and stall.
  input  wire bfa_pkg::bfa_mode_e mode,
  input  wire logic               hold,
  // Product stream in.
  input  wire logic               inValid,
  output logic                    inReady,
  input  wire logic               inGroupStart,
  input  wire bfa_pkg::bfa_cplx_s inProduct,
  // Butterfly terms out, shared with RAM write bytes.
  output logic                    outValid,
  output bfa_pkg::bfa_cplx_s      outTerm,
  // Accumulation RAM byte bus.
  output logic                    ramWrite,
  output logic                    ramRead,
  input  wire bfa_pkg::bfa_byte_s ramRdByte
);
  localparam int PW = bfa_pkg::PROD_W;
  localparam int IW = $bits(bfa_pkg::bfa_item_s);

  // FIFO output side.
  logic [IW-1:0]        fifoData;    // Raw entry.
  logic                 fifoValid;   // Entry available.
  logic                 fifoReady;   // Datapath may drain.
  bfa_pkg::bfa_item_s   item;        // Entry as a struct.
  logic                 step;        // One product advances the datapath.
  logic                 groupStart;  // Current product opens a group.
  logic signed [PW-1:0] prodPart [2];  // Real and imaginary product.
  logic [7:0]           rdPart   [2];  // Real and imaginary RAM byte.
  logic signed [31:0]   prodExt  [2];  // Sign-extended products.

  // Mode decode.
  logic isAcc;  // Accumulate mode.
  logic isR4;   // Radix-4 mode.
  logic isR2;   // Radix-2 mode.

  // Schedules.
  logic [2:0] accPhase;  // Phase for the next product, accumulate.
  logic [1:0] bfPhase;   // Phase for the next product, butterfly.
  logic [2:0] curAcc;    // Phase of the current product, accumulate.
  logic [1:0] curBf;     // Phase of the current product, butterfly.

  // Accumulators, one per component.
  logic [31:0] accF [2];      // Running totals.
  logic [23:0] accG [2];      // Staged unsent bytes.
  logic [31:0] accH [2];      // Readback from RAM.
  logic [7:0]  next_wrByte [2];  // Byte to write this step.

  // Butterfly registers, one per component.
  logic signed [PW-1:0] prevP     [2];  // Previous product.
  logic signed [PW-1:0] pairX     [2];  // First of a pair.
  logic signed [PW-1:0] pairY     [2];  // Second of a pair.
  logic signed [PW-1:0] s1        [2];  // First-stage result row.
  logic signed [PW-1:0] acDif     [2];  // Copy of the A-C difference.
  logic signed [PW-1:0] acSum     [2];  // Copy of the A+C sum for the second term.
  logic signed [PW-1:0] bfE       [2];  // Upper input hold register.
  logic signed [PW-1:0] holdSum   [2];  // Held B+D (or X+Z).
  logic signed [PW-1:0] holdCross [2];  // Held cross difference.
  logic signed [PW-1:0] upperOp   [2];  // Second-stage upper operand.
  logic signed [PW-1:0] lowerOp   [2];  // Second-stage lower operand.
  logic signed [PW-1:0] next_term [2];  // Second-stage result.
  logic                 selE;           // Upper input mux select.
  logic [4:0]           fill;           // Products seen, per pipeline slot.

  // RULE_18 - static mode decode
  always_comb begin
    isAcc = 1'b0;
    isR4 = 1'b0;
    isR2 = 1'b0;
    case (mode)
      bfa_pkg::BFA_MODE_ACC: isAcc = 1'b1;
      bfa_pkg::BFA_MODE_R4: isR4 = 1'b1;
      bfa_pkg::BFA_MODE_R2: isR2 = 1'b1;
      default: isAcc = 1'b0;
    endcase
  end

  bfa_fifo #(
    .WIDTH (IW),
    .DEPTH (bfa_pkg::FIFO_DEPTH)
  ) productFifo (
    .clock    (clock),
    .rst      (rst),
    .clkEn    (clkEn),
    .inValid  (inValid),
    .inReady  (inReady),
    .inData   ({inGroupStart, inProduct}),
    .outValid (fifoValid),
    .outReady (fifoReady),
    .outData  (fifoData)
  );

  // The whole datapath advances only when a product is there and nothing stalls.
  assign fifoReady = clkEn & ~hold;
  assign item = bfa_pkg::bfa_item_s'(fifoData);
  assign step = fifoReady & fifoValid;
  assign groupStart = item.groupStart;
  assign prodPart[0] = item.prod.re;
  assign prodPart[1] = item.prod.im;
  assign rdPart[0] = ramRdByte.re;
  assign rdPart[1] = ramRdByte.im;
  assign prodExt[0] = {{16{prodPart[0][PW-1]}}, prodPart[0]};
  assign prodExt[1] = {{16{prodPart[1][PW-1]}}, prodPart[1]};

  // RULE_19 - group strobe realigns
  assign curAcc = groupStart ? bfa_pkg::ACC_FIRST_PHASE : accPhase;
  assign curBf = groupStart ? bfa_pkg::BF_FIRST_PHASE : bfPhase;

  // RULE_13 - carry counting upper half
  // The low half is a 16-bit adder; the high half only steps by the carry and the sign.
  function automatic logic [31:0] accAdd(input logic [31:0] base,
                                         input logic signed [15:0] p);
    logic [16:0] low;
    logic [15:0] up;
    low = {1'b0, base[15:0]} + {1'b0, p};
    up = base[31:16] + {15'h0000, low[16]} - {15'h0000, p[15]};
    return {up, low[15:0]};
  endfunction

  // Schedule counters; both wrap by their own width.
  always_ff @(posedge clock) begin
    if (rst) begin
      accPhase <= bfa_pkg::ACC_FIRST_PHASE;
      bfPhase <= bfa_pkg::BF_FIRST_PHASE;
    end else if (step) begin
      // RULE_04 - wrap after cycle 8
      accPhase <= curAcc + 3'h1;
      bfPhase <= curBf + 2'h1;
    end
  end

  // Byte to send: the low byte of the total first, then the staged bytes.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      next_wrByte[i] = (curAcc == bfa_pkg::ACC_FIRST_PHASE) ? accF[i][7:0] : accG[i][7:0];
    end
  end

  // RULE_05 - both accumulators in parallel
  // RULE_15 - 16-bit in, 32-bit totals
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        accF[i] <= bfa_pkg::ACC_RESET;
        accG[i] <= bfa_pkg::STAGE_RESET;
        accH[i] <= bfa_pkg::ACC_RESET;
      end
    end else if (step && isAcc) begin
      for (int i = 0; i < 2; i++) begin
        if (curAcc == bfa_pkg::ACC_FIRST_PHASE) begin
          // RULE_01 - stage, send, reload
          accG[i] <= accF[i][31:8];
          accF[i] <= accAdd(accH[i], prodPart[i]);
        end else if (curAcc <= bfa_pkg::ACC_LAST_WRITE) begin
          // RULE_02 - shift staged bytes out
          accG[i] <= {8'h00, accG[i][23:8]};
          accF[i] <= accAdd(accF[i], prodPart[i]);
        end else begin
          // RULE_03 - read bytes, low first
          accH[i] <= {rdPart[i], accH[i][31:8]};
          accF[i] <= accAdd(accF[i], prodPart[i]);
        end
      end
    end
  end

  // RULE_16 - four byte cycles each way
  always_ff @(posedge clock) begin
    if (rst) begin
      ramWrite <= 1'b0;
    end else if (clkEn) begin
      ramWrite <= step && isAcc && (curAcc <= bfa_pkg::ACC_LAST_WRITE);
    end
  end
  assign ramRead = step && isAcc && (curAcc >= bfa_pkg::ACC_FIRST_READ);

  // RULE_09 - first stage, paired operands
  // RULE_06 - 16-bit wrapping results
  // Even phases take the sum, odd phases the difference and latch the next pair.
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        prevP[i] <= bfa_pkg::TERM_RESET;
        pairX[i] <= bfa_pkg::TERM_RESET;
        pairY[i] <= bfa_pkg::TERM_RESET;
        s1[i] <= bfa_pkg::TERM_RESET;
      end
    end else if (step && !isAcc) begin
      for (int i = 0; i < 2; i++) begin
        prevP[i] <= prodPart[i];
        if (curBf[0]) begin
          // RULE_07 - second of a pair arrives
          pairX[i] <= prevP[i];
          pairY[i] <= prodPart[i];
          s1[i] <= pairX[i] - pairY[i];
        end else begin
          s1[i] <= pairX[i] + pairY[i];
        end
      end
    end
  end

  // RULE_10 - hold register and its mux
  // The select moves at odd cycle ends and the register loads at even ones, so
  // the A-C difference survives after the first-stage row is overwritten.
  always_ff @(posedge clock) begin
    if (rst) begin
      selE <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        bfE[i] <= bfa_pkg::TERM_RESET;
        acDif[i] <= bfa_pkg::TERM_RESET;
      end
    end else if (step && isR4) begin
      if (!curBf[0]) begin
        selE <= (curBf == bfa_pkg::BF_FIRST_PHASE);
      end
      for (int i = 0; i < 2; i++) begin
        if (curBf == bfa_pkg::BF_FIRST_PHASE) begin
          acDif[i] <= s1[i];
        end
        if (curBf[0]) begin
          bfE[i] <= selE ? acDif[i] : s1[i];
        end
      end
    end
  end

  // Lower operand holds: own sum after phase 1, the other part's difference after phase 2.
  // The A+C copy is taken at phase 1 too, since the hold register moves on to A-C
  // one term before the second term has used A+C.
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        holdSum[i] <= bfa_pkg::TERM_RESET;
        holdCross[i] <= bfa_pkg::TERM_RESET;
        acSum[i] <= bfa_pkg::TERM_RESET;
      end
    end else if (step && isR4) begin
      for (int i = 0; i < 2; i++) begin
        if (curBf == 2'h1) begin
          holdSum[i] <= s1[i];
          acSum[i] <= bfE[i];
        end
        if (curBf == 2'h2) begin
          holdCross[i] <= s1[1 - i];
        end
      end
    end
  end

  // RULE_08 - second stage operands
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      upperOp[i] = bfE[i];
      lowerOp[i] = holdCross[i];
      next_term[i] = bfa_pkg::TERM_RESET;
      if (isR2) begin
        // RULE_12 - bypass second stage
        upperOp[i] = s1[i];
        lowerOp[i] = bfa_pkg::TERM_RESET;
        next_term[i] = upperOp[i] + lowerOp[i];
      end else begin
        if (curBf == 2'h1) begin
          lowerOp[i] = s1[i];
        end else if (curBf == 2'h2) begin
          // The hold register already shows A-C here, so the A+C copy feeds the top.
          upperOp[i] = acSum[i];
          lowerOp[i] = holdSum[i];
        end else if (curBf == 2'h0) begin
          // The hold register took the next group's A+C; the A-C copy still stands.
          upperOp[i] = acDif[i];
        end
        // Real adds on phases 1 and 3; imaginary adds on phases 1 and 0.
        if ((curBf == 2'h1) || (i == 0 && curBf == 2'h3) || (i == 1 && curBf == 2'h0)) begin
          next_term[i] = upperOp[i] + lowerOp[i];
        end else begin
          next_term[i] = upperOp[i] - lowerOp[i];
        end
      end
    end
  end

  // Pipeline fill marks when a real term reaches the output.
  always_ff @(posedge clock) begin
    if (rst) begin
      fill <= 5'h00;
    end else if (step && !isAcc) begin
      fill <= {fill[3:0], 1'b1};
    end
  end

  // RULE_11 - registered output term
  // RULE_14 - shared pins carry RAM bytes
  always_ff @(posedge clock) begin
    if (rst) begin
      outValid <= 1'b0;
      outTerm <= '0;
    end else if (clkEn) begin
      outValid <= step && ((isR4 && fill[bfa_pkg::R4_LATENCY - 1]) ||
                           (isR2 && fill[bfa_pkg::R2_LATENCY - 1]));
      if (step && isAcc) begin
        outTerm.re <= {8'h00, next_wrByte[0]};
        outTerm.im <= {8'h00, next_wrByte[1]};
      end else if (step) begin
        outTerm.re <= next_term[0];
        outTerm.im <= next_term[1];
      end
    end
  end

  // RULE_17 - single clock
  // Every process above is clocked by clock alone.

  // Rule checks
  a_acc_first_byte: assert property (@(posedge clock) disable iff (rst) // RULE_01
    (step && isAcc && curAcc == 3'h0) |=> (ramWrite && outTerm.re[7:0] == $past(accF[0][7:0])))
    else $error("First write byte is not the low byte of the total.");
  a_acc_reload: assert property (@(posedge clock) disable iff (rst) // RULE_01
    (step && isAcc && curAcc == 3'h0) |=> (accF[0] == $past(accH[0]) + $past(prodExt[0])
      && accG[0] == $past(accF[0][31:8])))
    else $error("Cycle one reload or staging is wrong.");
  a_acc_staged_bytes: assert property (@(posedge clock) disable iff (rst) // RULE_02
    (step && isAcc && curAcc >= 3'h1 && curAcc <= 3'h3) |=>
      (ramWrite && outTerm.re[7:0] == $past(accG[0][7:0])
       && accF[0] == $past(accF[0]) + $past(prodExt[0])))
    else $error("Staged byte or running sum is wrong.");
  a_acc_read_byte: assert property (@(posedge clock) disable iff (rst) // RULE_03
    (step && isAcc && curAcc >= 3'h4) |-> ramRead ##1 (!ramWrite && accH[0][31:24] ==
      $past(ramRdByte.re)))
    else $error("Readback byte not captured.");
  a_acc_wrap_phase: assert property (@(posedge clock) disable iff (rst) // RULE_04
    (step && isAcc && !groupStart && accPhase == 3'h7) |=> (accPhase == 3'h0))
    else $error("Accumulate schedule did not wrap.");
  a_acc_imag_byte: assert property (@(posedge clock) disable iff (rst) // RULE_05
    (step && isAcc && curAcc == 3'h0) |=> (outTerm.im[7:0] == $past(accF[1][7:0])))
    else $error("Imaginary write byte is wrong.");
  a_stage1_sum: assert property (@(posedge clock) disable iff (rst) // RULE_09
    (step && !isAcc && !curBf[0]) |=> (s1[0] == 16'($past(pairX[0]) + $past(pairY[0]))))
    else $error("First stage sum is wrong.");
  a_hold_even_load: assert property (@(posedge clock) disable iff (rst) // RULE_10
    (step && isR4 && !curBf[0]) |=> $stable(bfE[0]))
    else $error("Hold register loaded on an odd cycle.");
  a_r2_bypass_out: assert property (@(posedge clock) disable iff (rst) // RULE_12
    (step && isR2) |=> (outTerm.re == $past(s1[0]) && outTerm.im == $past(s1[1])))
    else $error("Radix-2 output is not the first stage result.");
  a_r4_term_rate: assert property (@(posedge clock) disable iff (rst) // RULE_11
    (step && isR4 && fill[4]) ##1 (step && isR4) |=> outValid)
    else $error("Radix-4 term missing in a cycle.");
  a_group_align: assert property (@(posedge clock) disable iff (rst) // RULE_19
    (step && groupStart) |=> (accPhase == 3'h1 && bfPhase == 2'h1))
    else $error("Group strobe did not realign the schedules.");
endmodule

// ### logic/bfa_pkg.sv
// Shared constants and types of the butterfly / accumulate datapath.
// Assumes a single clock; every user names items as bfa_pkg::name.
package bfa_pkg;

  // Width of one real or imaginary product and of one butterfly term.
  localparam int PROD_W = 16;
  // Width of an accumulated total.
  localparam int ACC_W = 32;
  // Width of the accumulation RAM byte bus.
  localparam int BYTE_W = 8;
  // Width of the staging register that holds the unsent bytes.
  localparam int STAGE_W = 24;
  // Depth of the product FIFO in front of the datapath.
  localparam int FIFO_DEPTH = 4;
  // Rate of the clock in MHz, for reference only; no timing count depends on it.
  localparam int CLOCK_MHZ = 250;

  // Accumulate schedule: eight steps, phase 0 is the first product of a group.
  localparam logic [2:0] ACC_FIRST_PHASE = 3'h0;
  localparam logic [2:0] ACC_LAST_WRITE = 3'h3;
  localparam logic [2:0] ACC_FIRST_READ = 3'h4;
  localparam logic [2:0] ACC_LAST_PHASE = 3'h7;

  // Butterfly schedule: four products A, C, B, D at phases 0 to 3.
  localparam logic [1:0] BF_FIRST_PHASE = 2'h0;
  localparam logic [1:0] BF_LAST_PHASE = 2'h3;

  // Steps from a product entering to its term leaving, per butterfly mode.
  localparam int R4_LATENCY = 5;
  localparam int R2_LATENCY = 3;

  // Reset values of the accumulator, staging, readback and butterfly term registers.
  localparam logic [ACC_W-1:0] ACC_RESET = 32'h0000_0000;
  localparam logic [STAGE_W-1:0] STAGE_RESET = 24'h00_0000;
  localparam logic [PROD_W-1:0] TERM_RESET = 16'h0000;

  // Operating mode, chosen statically.
  typedef enum logic [2:0] {
    BFA_MODE_ACC = 3'b001,
    BFA_MODE_R4  = 3'b010,
    BFA_MODE_R2  = 3'b100
  } bfa_mode_e;

  // One complex value in 16-bit two's complement.
  typedef struct packed {
    logic signed [PROD_W-1:0] re;
    logic signed [PROD_W-1:0] im;
  } bfa_cplx_s;

  // One RAM byte for each of the two accumulators.
  typedef struct packed {
    logic [BYTE_W-1:0] re;
    logic [BYTE_W-1:0] im;
  } bfa_byte_s;

  // One FIFO entry: a product and the flag marking the first of a group.
  typedef struct packed {
    logic      groupStart;
    bfa_cplx_s prod;
  } bfa_item_s;

endpackage

// ### sim/bfa_ram_model.sv
// Byte-wide accumulation RAM standing beside the datapath, one word deep.
// Assumes the datapath's strobes and bytes change only at enabled clock edges.
module bfa_ram_model (
  // Clock and chip-wide freeze.
  input  wire logic               clock,
  input  wire logic               clkEn,
  // Byte bus strobes and data.
  input  wire logic               ramWrite,
  input  wire logic               ramRead,
  input  wire bfa_pkg::bfa_byte_s wrByte,
  output bfa_pkg::bfa_byte_s      ramRdByte
);
  timeunit 1ns;
  timeprecision 1ps;

  bfa_pkg::bfa_byte_s mem [4];  // The four bytes of the stored word.
  bfa_pkg::bfa_byte_s lastByte; // Last byte handed out, to spoil the idle bus.
  logic [1:0]         wrIdx;    // Byte lane of the next write.
  logic [1:0]         rdIdx;    // Byte lane of the next read.

  initial begin
    for (int i = 0; i < 4; i++) mem[i] = 16'h0000;
    lastByte = 16'h0000;
    wrIdx = 2'h0;
    rdIdx = 2'h0;
  end

  // word as four bytes
  // Each enabled strobe moves one byte, low byte first, in consecutive lanes.
  always @(posedge clock) begin
    if (clkEn) begin
      if (ramWrite) begin
        mem[wrIdx] <= wrByte;
        wrIdx <= wrIdx + 2'h1;
      end
      if (ramRead) begin
        lastByte <= ramRdByte;
        rdIdx <= rdIdx + 2'h1;
      end
    end
  end

  // Outside a read the bus shows the inverse of the last byte, never a stale copy.
  assign ramRdByte = ramRead ? mem[rdIdx] : bfa_pkg::bfa_byte_s'(~lastByte);
endmodule

// ### sim/butterfly_accumulate_datapath_test.sv
// Self-checking bench of the butterfly and accumulate datapath.
// Assumes the datapath and the RAM model are compiled before it.
module butterfly_accumulate_datapath_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock = 1'b0, rst = 1'b1, clkEn = 1'b1, hold = 1'b0;
  logic inValid = 1'b0, inGroupStart = 1'b0, outValid, inReady, ramWrite, ramRead;
  bfa_pkg::bfa_mode_e mode = bfa_pkg::BFA_MODE_ACC;
  bfa_pkg::bfa_cplx_s inProduct = 32'h0000_0000, outTerm;
  bfa_pkg::bfa_byte_s ramRdByte;
  logic [31:0] terms [$];      // Butterfly terms seen on the output.
  logic [7:0]  reB [$], imB [$]; // Write bytes seen on the output.
  int bad_count = 0, comparisons = 0;

  always #2 clock = ~clock;

  bfa_datapath dut_u (.clock(clock), .rst(rst), .clkEn(clkEn), .mode(mode), .hold(hold),
    .inValid(inValid), .inReady(inReady), .inGroupStart(inGroupStart), .inProduct(inProduct),
    .outValid(outValid), .outTerm(outTerm), .ramWrite(ramWrite), .ramRead(ramRead),
    .ramRdByte(ramRdByte));

  bfa_ram_model ram_u (.clock(clock), .clkEn(clkEn), .ramWrite(ramWrite), .ramRead(ramRead),
    .wrByte({outTerm.re[7:0], outTerm.im[7:0]}), .ramRdByte(ramRdByte));

  // Collects what the datapath hands out at each enabled edge.
  always @(posedge clock) begin
    if (!rst && clkEn) begin
      if (outValid === 1'b1) terms.push_back(outTerm);
      if (ramWrite === 1'b1) begin
        reB.push_back(outTerm.re[7:0]);
        imB.push_back(outTerm.im[7:0]);
      end
    end
  end

  // Reports a mismatch at once and counts every comparison.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Ends the run with the verdict.
  task automatic give_verdict();
    if (bad_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Makes a distinct product for stream position i.
  function automatic bfa_pkg::bfa_cplx_s mk(input int i);
    mk.re = 16'(i * 16'h1357 + 16'h7f00);
    mk.im = 16'(16'h8100 - i * 16'h0a31);
  endfunction

  // Resets for 12 cycles in the given mode and clears the collectors.
  task automatic reset_in(input bfa_pkg::bfa_mode_e m);
    rst <= 1'b1;
    mode <= m;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    terms.delete();
    reB.delete();
    imB.delete();
  endtask

  // Offers one product and holds it until an edge where it is accepted.
  task automatic push(input int i, input logic gs);
    logic ok;
    int n;
    inValid <= 1'b1;
    inProduct <= mk(i);
    inGroupStart <= gs;
    n = 0;
    do begin
      @(negedge clock);
      ok = inReady;
      @(posedge clock);
      n++;
    end while (ok !== 1'b1 && n < 100);
    if (n >= 100) check({31'h0, ok}, 32'h1);
  endtask

  // Four groups of eight products through a one-word RAM. The readback in a group
  // returns the word written in that same group, which the next group adds onto.
  task automatic test_accumulate();
    logic signed [31:0] sr [4], si [4];
    bfa_pkg::bfa_cplx_s p;
    reset_in(bfa_pkg::BFA_MODE_ACC);
    check({31'h0, inReady}, 32'h1);
    sr[0] = 32'h0;
    si[0] = 32'h0;
    for (int g = 0; g < 3; g++) begin
      // Word g+1 is the word written two groups back plus the products of group g.
      sr[g+1] = (g > 0) ? sr[g-1] : sr[0];
      si[g+1] = (g > 0) ? si[g-1] : si[0];
      for (int k = 0; k < 8; k++) begin
        p = mk(8 * g + k);
        sr[g+1] = sr[g+1] + 32'(p.re);
        si[g+1] = si[g+1] + 32'(p.im);
      end
    end
    for (int i = 0; i < 32; i++) push(i, (i % 8) == 0);
    inValid <= 1'b0;
    repeat (20) @(posedge clock);
    for (int w = 0; w < 4; w++) begin
      check({reB[4*w+3], reB[4*w+2], reB[4*w+1], reB[4*w]}, sr[w]);
      check({imB[4*w+3], imB[4*w+2], imB[4*w+1], imB[4*w]}, si[w]);
    end
    check(32'(terms.size()), 32'h0);
  endtask

  // Radix-4 groups fed while stalled until the FIFO refuses, then drained.
  task automatic test_radix4();
    bfa_pkg::bfa_cplx_s a, b, c, d;
    reset_in(bfa_pkg::BFA_MODE_R4);
    hold <= 1'b1;
    for (int i = 0; i < 4; i++) push(i, (i % 4) == 0);
    inValid <= 1'b0;
    @(negedge clock);
    check({31'h0, inReady}, 32'h0);
    @(posedge clock);
    hold <= 1'b0;
    for (int i = 4; i < 16; i++) push(i, (i % 4) == 0);
    inValid <= 1'b0;
    repeat (20) @(posedge clock);
    for (int g = 0; g < 2; g++) begin
      a = mk(4 * g);
      c = mk(4 * g + 1);
      b = mk(4 * g + 2);
      d = mk(4 * g + 3);
      check(terms[4*g], {a.re + c.re + b.re + d.re, a.im + c.im + b.im + d.im});
      check(terms[4*g+1], {a.re + c.re - b.re - d.re, a.im + c.im - b.im - d.im});
      check(terms[4*g+2], {a.re - c.re + b.im - d.im, a.im - c.im - b.re + d.re});
      check(terms[4*g+3], {a.re - c.re - b.im + d.im, a.im - c.im + b.re - d.re});
    end
  endtask

  // Radix-2 pairs with a clock-enable pause in mid-stream.
  task automatic test_radix2();
    bfa_pkg::bfa_cplx_s a, c;
    reset_in(bfa_pkg::BFA_MODE_R2);
    for (int i = 0; i < 8; i++) begin
      push(i, (i % 2) == 0);
      if (i == 2) begin
        inValid <= 1'b0;
        clkEn <= 1'b0;
        repeat (3) @(posedge clock);
        clkEn <= 1'b1;
      end
    end
    inValid <= 1'b0;
    repeat (20) @(posedge clock);
    for (int k = 0; k < 2; k++) begin
      a = mk(2 * k);
      c = mk(2 * k + 1);
      check(terms[2*k], {a.re + c.re, a.im + c.im});
      check(terms[2*k+1], {a.re - c.re, a.im - c.im});
    end
  endtask

  // Cuts a hang short well beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    give_verdict();
  end

  // Main sequence.
  initial begin
    test_accumulate();
    test_radix4();
    test_radix2();
    give_verdict();
  end
endmodule
